//--- uodr_defines.vh
// Constants for the OTG detect and device reset block.
// Assumes inclusion by bare name from the design files.
`ifndef UODR_DEFINES_VH
`define UODR_DEFINES_VH

// ----------------------------------------------------------------------
// Timer pages
// ----------------------------------------------------------------------
`define UODR_PAGE_AWAIT     2'h0
`define UODR_PAGE_PULSE     2'h1
`define UODR_PAGE_PDOWN     2'h2
`define UODR_PAGE_SRP       2'h3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define UODR_RST_PAGE       2'h0
`define UODR_RST_VALUE      2'h0
`define UODR_RST_CFG        8'h00

// ----------------------------------------------------------------------
// Time-outs in microseconds
// ----------------------------------------------------------------------
`define UODR_T_AWAIT0       32'd20000
`define UODR_T_AWAIT1       32'd50000
`define UODR_T_AWAIT2       32'd70000
`define UODR_T_AWAIT3       32'd100000
`define UODR_T_PULSE0       32'd15000
`define UODR_T_PULSE1       32'd23000
`define UODR_T_PULSE2       32'd31000
`define UODR_T_PULSE3       32'd40000
`define UODR_T_PDOWN0       32'd93000
`define UODR_T_PDOWN1       32'd105000
`define UODR_T_PDOWN2       32'd118000
`define UODR_T_PDOWN3       32'd131000
`define UODR_T_SRP0         32'd10
`define UODR_T_SRP1         32'd100
`define UODR_T_SRP2         32'd1000
`define UODR_T_SRP3         32'd11000

// Clock cycles per microsecond at 200 MHz
`define UODR_CYC_PER_US     32'd200

// ----------------------------------------------------------------------
// Speed status codes
// ----------------------------------------------------------------------
`define UODR_SPD_FULL       2'h0
`define UODR_SPD_HIGH       2'h1

`endif

//--- uodr_timeout_rom.v
// Table of OTG time-outs in clock cycles, registered output.
// Assumes the 200 MHz system clock; page and value come from the core.
`timescale 1ns/1ps
`include "uodr_defines.vh"

module uodr_timeout_rom (
  input  wire        clk_sys_i,
  input  wire        rst_n_i,
  input  wire [1:0]  page_i,
  input  wire [1:0]  value_i,
  output reg  [31:0] cycles_o
);

  reg [31:0] nxt_us;

  // ----------------------------------------------------------------------
  // Time-out selection
  // ----------------------------------------------------------------------
  always @* begin
    nxt_us = `UODR_T_AWAIT0;
    case ({page_i, value_i})
      {`UODR_PAGE_AWAIT, 2'h0}: nxt_us = `UODR_T_AWAIT0;
      {`UODR_PAGE_AWAIT, 2'h1}: nxt_us = `UODR_T_AWAIT1;
      {`UODR_PAGE_AWAIT, 2'h2}: nxt_us = `UODR_T_AWAIT2;
      {`UODR_PAGE_AWAIT, 2'h3}: nxt_us = `UODR_T_AWAIT3;
      {`UODR_PAGE_PULSE, 2'h0}: nxt_us = `UODR_T_PULSE0;
      {`UODR_PAGE_PULSE, 2'h1}: nxt_us = `UODR_T_PULSE1;
      {`UODR_PAGE_PULSE, 2'h2}: nxt_us = `UODR_T_PULSE2;
      {`UODR_PAGE_PULSE, 2'h3}: nxt_us = `UODR_T_PULSE3;
      {`UODR_PAGE_PDOWN, 2'h0}: nxt_us = `UODR_T_PDOWN0;
      {`UODR_PAGE_PDOWN, 2'h1}: nxt_us = `UODR_T_PDOWN1;
      {`UODR_PAGE_PDOWN, 2'h2}: nxt_us = `UODR_T_PDOWN2;
      {`UODR_PAGE_PDOWN, 2'h3}: nxt_us = `UODR_T_PDOWN3;
      {`UODR_PAGE_SRP, 2'h0}:   nxt_us = `UODR_T_SRP0;
      {`UODR_PAGE_SRP, 2'h1}:   nxt_us = `UODR_T_SRP1;
      {`UODR_PAGE_SRP, 2'h2}:   nxt_us = `UODR_T_SRP2;
      {`UODR_PAGE_SRP, 2'h3}:   nxt_us = `UODR_T_SRP3;
      default:                  nxt_us = `UODR_T_AWAIT0;
    endcase
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cycles_o <= 32'h0;
    end else begin
      cycles_o <= nxt_us * `UODR_CYC_PER_US;
    end
  end

endmodule

//--- uodr_core.v
// OTG plug detection, role selection, timer window and device reset.
// Assumes pads and comparators are asynchronous; software side is
// synchronous to clk_sys_i and presents one-cycle write strobes.
//
// Overview of operation
// - Page selector picks one of four timers
// - Page 0 values give 20/50/70/100 ms
// - Page 1 values give 15/23/31/40 ms
// - Page 2 values give 93/105/118/131 ms
// - Page 3 values give 10us/100us/1ms/11ms
// - Page/value writes need prior unlock write
// - Device role: power bit follows session comparator
// - Host role: power bit uses hysteresis
// - Power bit change sets transition flag
// - Status bits track regardless of enable
// - Role from pin or software select
// - Reset: pin select on, role device
// - Role status change sets role flag
// - Hardware reset: freeze, detach, deallocate
// - Pull-up only when attached and powered
// - Enable in device role enters Idle
// - Disable or host role resets device
// - Bus reset resets control endpoint, disables the rest
// - Bus reset negotiates and reports speed
// - Endpoint reset keeps config, toggle, enable
// - Bus reset keeps endpoint interrupt sources
// - Toggle-reset set bit sets toggle reset
`timescale 1ns/1ps
`include "uodr_defines.vh"

module uodr_core #(
  parameter NUM_EP = 8
) (
  input  wire              clk_sys_i,
  input  wire              rst_n_i,
  // Timer window
  input  wire              timer_unlock_wr_i,
  input  wire              timer_wr_i,
  input  wire [1:0]        timer_page_select_i,
  input  wire [1:0]        timer_timeout_value_i,
  output reg  [1:0]        timer_page_select_o,
  output reg  [1:0]        timer_timeout_value_o,
  output reg  [31:0]       timer_cycles_o,
  // Pads and comparators
  input  wire              session_valid_cmp_i,
  input  wire              high_power_valid_cmp_i,
  input  wire              role_id_pin_i,
  // General control
  input  wire              controller_enable_i,
  input  wire              id_pin_enable_wr_i,
  input  wire              id_pin_enable_i,
  input  wire              software_role_select_i,
  input  wire              clock_freeze_wr_i,
  input  wire              clock_freeze_i,
  input  wire              detach_wr_i,
  input  wire              detach_i,
  input  wire              high_speed_ok_i,
  input  wire              bus_power_change_clr_i,
  input  wire              role_change_clr_i,
  // Bus reset from line state logic
  input  wire              bus_reset_i,
  input  wire              host_hs_capable_i,
  input  wire              end_of_bus_reset_clr_i,
  // Endpoints
  input  wire [NUM_EP-1:0] endpoint_enable_wr_i,
  input  wire [NUM_EP-1:0] endpoint_enable_i,
  input  wire [NUM_EP-1:0] endpoint_reset_bit_i,
  input  wire [NUM_EP-1:0] toggle_reset_set_i,
  input  wire [NUM_EP-1:0] endpoint_event_i,
  input  wire [NUM_EP-1:0] toggle_reset_done_i,
  // Status
  output reg               bus_power_o,
  output reg               bus_power_change_flag_o,
  output reg               role_status_o,
  output reg               role_change_flag_o,
  output reg               id_pin_enable_o,
  output reg               clock_freeze_o,
  output reg               detach_o,
  output reg               pullup_dp_o,
  output reg               pullup_dm_o,
  output reg  [1:0]        speed_o,
  output reg               end_of_bus_reset_flag_o,
  output reg  [2:0]        device_state_o,
  output reg  [NUM_EP-1:0] endpoint_enabled_o,
  output reg  [NUM_EP-1:0] endpoint_in_reset_o,
  output reg  [NUM_EP-1:0] memory_allocate_clr_o,
  output reg  [NUM_EP-1:0] endpoint_irq_src_o,
  output reg  [NUM_EP-1:0] toggle_reset_o
);

  // ----------------------------------------------------------------------
  // Device states, one-hot
  // ----------------------------------------------------------------------
  localparam ST_RESET = 3'b001;
  localparam ST_IDLE  = 3'b010;
  localparam ST_RUN   = 3'b100;

  // ----------------------------------------------------------------------
  // Pad synchronisers, three stages
  // ----------------------------------------------------------------------
  reg [2:0] sess_sync_ff;
  reg [2:0] high_sync_ff;
  reg [2:0] id_sync_ff;
  reg       sess_ff;
  reg       high_ff;
  reg       id_pin_ff;

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sess_sync_ff <= 3'h0;
      high_sync_ff <= 3'h0;
      id_sync_ff   <= 3'h7;
      sess_ff      <= 1'b0;
      high_ff      <= 1'b0;
      id_pin_ff    <= 1'b1;
    end else begin
      sess_sync_ff <= {sess_sync_ff[1:0], session_valid_cmp_i};
      high_sync_ff <= {high_sync_ff[1:0], high_power_valid_cmp_i};
      id_sync_ff   <= {id_sync_ff[1:0], role_id_pin_i};
      if (sess_sync_ff[2] == sess_sync_ff[1]) begin
        sess_ff <= sess_sync_ff[2];
      end
      if (high_sync_ff[2] == high_sync_ff[1]) begin
        high_ff <= high_sync_ff[2];
      end
      if (id_sync_ff[2] == id_sync_ff[1]) begin
        id_pin_ff <= id_sync_ff[2];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Timer window
  // ----------------------------------------------------------------------
  reg        unlock_ff;
  wire [31:0] rom_cycles;

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      unlock_ff             <= 1'b0;
      timer_page_select_o   <= `UODR_RST_PAGE;
      timer_timeout_value_o <= `UODR_RST_VALUE;
      timer_cycles_o        <= 32'h0;
    end else begin
      timer_cycles_o <= rom_cycles;
      if (timer_wr_i && unlock_ff) begin
        timer_page_select_o   <= timer_page_select_i;
        timer_timeout_value_o <= timer_timeout_value_i;
        unlock_ff             <= 1'b0;
      end else if (timer_unlock_wr_i) begin
        unlock_ff <= 1'b1;
      end
    end
  end

  uodr_timeout_rom u_rom (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .page_i    (timer_page_select_o),
    .value_i   (timer_timeout_value_o),
    .cycles_o  (rom_cycles)
  );

  // ----------------------------------------------------------------------
  // Role and bus power
  // ----------------------------------------------------------------------
  reg  nxt_role;
  reg  nxt_power;

  always @* begin
    nxt_role = id_pin_enable_o ? id_pin_ff : software_role_select_i;
    nxt_power = bus_power_o;
    if (role_status_o) begin
      nxt_power = sess_ff;
    end else if (high_ff) begin
      nxt_power = 1'b1;
    end else if (!sess_ff) begin
      nxt_power = 1'b0;
    end
  end

  // Tracking ignores controller_enable_i
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      id_pin_enable_o         <= 1'b1;
      role_status_o           <= 1'b1;
      bus_power_o             <= 1'b0;
      bus_power_change_flag_o <= 1'b0;
      role_change_flag_o      <= 1'b0;
    end else begin
      if (id_pin_enable_wr_i) begin
        id_pin_enable_o <= id_pin_enable_i;
      end
      role_status_o <= nxt_role;
      bus_power_o   <= nxt_power;
      if (nxt_power != bus_power_o) begin
        bus_power_change_flag_o <= 1'b1;
      end else if (bus_power_change_clr_i) begin
        bus_power_change_flag_o <= 1'b0;
      end
      if (nxt_role != role_status_o) begin
        role_change_flag_o <= 1'b1;
      end else if (role_change_clr_i) begin
        role_change_flag_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Device mode state machine
  // ----------------------------------------------------------------------
  reg  [2:0] nxt_state;
  wire       dev_kill;
  reg        bus_reset_ff;
  wire       bus_reset_end;

  assign dev_kill      = !controller_enable_i || !role_status_o;
  assign bus_reset_end = bus_reset_ff && !bus_reset_i;

  always @* begin
    nxt_state = device_state_o;
    case (device_state_o)
      ST_RESET: begin
        if (!dev_kill) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (dev_kill) begin
          nxt_state = ST_RESET;
        end else if (!clock_freeze_o) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (dev_kill) begin
          nxt_state = ST_RESET;
        end else if (clock_freeze_o) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_RESET;
    endcase
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      device_state_o          <= ST_RESET;
      clock_freeze_o          <= 1'b1;
      detach_o                <= 1'b1;
      pullup_dp_o             <= 1'b0;
      pullup_dm_o             <= 1'b0;
      speed_o                 <= `UODR_SPD_FULL;
      end_of_bus_reset_flag_o <= 1'b0;
      bus_reset_ff            <= 1'b0;
    end else begin
      device_state_o <= nxt_state;
      if (clock_freeze_wr_i) begin
        clock_freeze_o <= clock_freeze_i;
      end
      if (nxt_state == ST_RESET) begin
        detach_o <= 1'b1;
      end else if (detach_wr_i) begin
        detach_o <= detach_i;
      end
      pullup_dp_o <= !detach_o && bus_power_o && (device_state_o != ST_RESET);
      pullup_dm_o <= 1'b0;
      bus_reset_ff <= bus_reset_i && (device_state_o == ST_RUN);
      if (device_state_o == ST_RESET) begin
        speed_o                 <= `UODR_SPD_FULL;
        end_of_bus_reset_flag_o <= 1'b0;
      end else begin
        if (bus_reset_ff) begin
          speed_o <= (host_hs_capable_i && high_speed_ok_i)
                     ? `UODR_SPD_HIGH : `UODR_SPD_FULL;
        end
        if (bus_reset_end) begin
          end_of_bus_reset_flag_o <= 1'b1;
        end else if (end_of_bus_reset_clr_i) begin
          end_of_bus_reset_flag_o <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Per-endpoint enable, reset and toggle reset
  // ----------------------------------------------------------------------
  genvar ep;
  generate
    for (ep = 0; ep < NUM_EP; ep = ep + 1) begin : g_ep
      always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          endpoint_enabled_o[ep]    <= 1'b0;
          endpoint_in_reset_o[ep]   <= 1'b0;
          memory_allocate_clr_o[ep] <= 1'b1;
          endpoint_irq_src_o[ep]    <= 1'b0;
          toggle_reset_o[ep]        <= 1'b0;
        end else if (device_state_o == ST_RESET) begin
          endpoint_enabled_o[ep]    <= 1'b0;
          endpoint_in_reset_o[ep]   <= 1'b0;
          memory_allocate_clr_o[ep] <= 1'b1;
          endpoint_irq_src_o[ep]    <= 1'b0;
          toggle_reset_o[ep]        <= 1'b0;
        end else begin
          memory_allocate_clr_o[ep] <= 1'b0;
          if (bus_reset_ff && ep != 0) begin
            endpoint_enabled_o[ep] <= 1'b0;
          end else if (endpoint_enable_wr_i[ep]) begin
            endpoint_enabled_o[ep] <= endpoint_enable_i[ep];
          end
          // Software reset bit held until written back to zero
          endpoint_in_reset_o[ep] <= endpoint_reset_bit_i[ep] ||
                                     (bus_reset_ff && ep == 0);
          // Interrupt sources survive a bus reset
          if (endpoint_event_i[ep]) begin
            endpoint_irq_src_o[ep] <= 1'b1;
          end else if (endpoint_reset_bit_i[ep]) begin
            endpoint_irq_src_o[ep] <= 1'b0;
          end
          if (toggle_reset_set_i[ep] || (bus_reset_ff && ep == 0)) begin
            toggle_reset_o[ep] <= 1'b1;
          end else if (toggle_reset_done_i[ep]) begin
            toggle_reset_o[ep] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule

//--- uodr_core_props.sv
// Concurrent checks on the ports of the OTG detect and device reset core.
// Assumes a bind onto uodr_core with NUM_EP handed on.
`timescale 1ns/1ps

module uodr_core_props #(
  parameter NUM_EP = 8
) (
  input  wire              clk_sys_i,
  input  wire              rst_n_i,
  input  wire              timer_wr_i,
  input  wire [1:0]        timer_page_select_o,
  input  wire [1:0]        timer_timeout_value_o,
  input  wire [31:0]       timer_cycles_o,
  input  wire              controller_enable_i,
  input  wire [NUM_EP-1:0] endpoint_enable_wr_i,
  input  wire [NUM_EP-1:0] endpoint_reset_bit_i,
  input  wire              bus_reset_i,
  input  wire              bus_power_o,
  input  wire              bus_power_change_flag_o,
  input  wire              role_status_o,
  input  wire              role_change_flag_o,
  input  wire              detach_o,
  input  wire              pullup_dp_o,
  input  wire              pullup_dm_o,
  input  wire              end_of_bus_reset_flag_o,
  input  wire [2:0]        device_state_o,
  input  wire [NUM_EP-1:0] endpoint_enabled_o,
  input  wire [NUM_EP-1:0] toggle_reset_o
);
  wire [3:0] tf = {timer_page_select_o, timer_timeout_value_o};
  wire       run = device_state_o == 3'h4;
  reg  [1:0] up_ff;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  // Edges since reset release, saturating
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i)
      up_ff <= 2'h0;
    else if (up_ff != 2'h3)
      up_ff <= up_ff + 2'h1;
  end

  chk_field_hold: assert property (!$past(timer_wr_i) |-> $stable(tf))
    else $error("timer fields moved without a write");
  chk_cycles_steady: assert property (up_ff == 2'h3 && $past(tf, 3) == tf &&
    $past(tf, 2) == tf && $past(tf) == tf |-> $stable(timer_cycles_o))
    else $error("time-out count moved with fields steady");
  chk_power_flag: assert property ($changed(bus_power_o) |-> bus_power_change_flag_o)
    else $error("power change without flag");
  chk_role_flag: assert property ($changed(role_status_o) |-> role_change_flag_o)
    else $error("role change without flag");
  chk_pullup_cause: assert property (pullup_dp_o |->
    $past(!detach_o && bus_power_o && device_state_o != 3'h1))
    else $error("pull-up without attach and power");
  chk_dm_idle: assert property (!pullup_dm_o)
    else $error("unexpected minus line pull-up");
  chk_disable_reset: assert property (!controller_enable_i |=>
    device_state_o == 3'h1 && detach_o)
    else $error("disabled device not in reset");
  chk_enter_idle: assert property (device_state_o == 3'h1 && controller_enable_i &&
    role_status_o |=> device_state_o == 3'h2)
    else $error("enable in device role did not reach idle");
  chk_bus_rst_ep: assert property ($rose(bus_reset_i) && run |-> ##[1:3]
    ((endpoint_enabled_o >> 1) == 0 && toggle_reset_o[0]))
    else $error("bus reset left endpoints enabled");
  chk_eor_flag: assert property ($fell(bus_reset_i) && run |->
    ##[1:2] end_of_bus_reset_flag_o)
    else $error("no end of bus reset flag");
  chk_ep_keep: assert property (|endpoint_reset_bit_i && endpoint_enable_wr_i == 0 &&
    !bus_reset_i && !$past(bus_reset_i) && controller_enable_i && device_state_o != 3'h1
    |=> $stable(endpoint_enabled_o))
    else $error("endpoint reset changed enable");
endmodule

//--- uodr_host_model.sv
// USB host or OTG peer: bus power comparators, plug and bus reset.
// Assumes the bench calls its tasks just after a clock edge.
`timescale 1ns/1ps

module uodr_host_model (
  input  wire clk_sys_i,
  output reg  session_o,
  output reg  high_o,
  output reg  id_o,
  output reg  bus_reset_o,
  output reg  hs_o
);
  initial begin
    session_o = 1'b0;
    high_o = 1'b0;
    id_o = 1'b1;
    bus_reset_o = 1'b0;
    hs_o = 1'b0;
  end

  // Level 0 none, 1 session only, 3 full power
  task vbus(input [1:0] lvl);
    begin
      session_o <= lvl[0];
      high_o <= lvl[1];
    end
  endtask

  // Mini-A plug pulls the pin low, none or Mini-B leaves it high
  task plug(input a_plug);
    id_o <= !a_plug;
  endtask

  task reset_bus(input [7:0] n, input hs);
    begin
      hs_o <= hs;
      bus_reset_o <= 1'b1;
      repeat (n) @(posedge clk_sys_i);
      bus_reset_o <= 1'b0;
    end
  endtask
endmodule

//--- tb_uodr_core.sv
// Self-checking bench for the OTG detect and device reset core.
// Assumes uodr_core, its checker and the host model are compiled first.
`timescale 1ns/1ps

module tb_uodr_core;
  localparam NUM_EP = 8;
  reg clk_sys_i, rst_n_i, timer_unlock_wr_i, timer_wr_i;
  reg [1:0] timer_page_select_i, timer_timeout_value_i;
  reg controller_enable_i, id_pin_enable_wr_i, id_pin_enable_i, software_role_select_i;
  reg clock_freeze_wr_i, clock_freeze_i, detach_wr_i, detach_i, high_speed_ok_i;
  reg bus_power_change_clr_i, role_change_clr_i, end_of_bus_reset_clr_i;
  reg [7:0] endpoint_enable_wr_i, endpoint_enable_i, endpoint_reset_bit_i;
  reg [7:0] toggle_reset_set_i, endpoint_event_i, toggle_reset_done_i;
  wire session_valid_cmp_i, high_power_valid_cmp_i, role_id_pin_i;
  wire bus_reset_i, host_hs_capable_i;
  wire [1:0] timer_page_select_o, timer_timeout_value_o, speed_o;
  wire [31:0] timer_cycles_o;
  wire bus_power_o, bus_power_change_flag_o, role_status_o, role_change_flag_o;
  wire id_pin_enable_o, clock_freeze_o, detach_o, pullup_dp_o, pullup_dm_o;
  wire end_of_bus_reset_flag_o;
  wire [2:0] device_state_o;
  wire [7:0] endpoint_enabled_o, endpoint_in_reset_o, memory_allocate_clr_o;
  wire [7:0] endpoint_irq_src_o, toggle_reset_o;
  integer n_errors = 0;
  integer n_checks = 0;
  reg [4:0] k;
  int unsigned tus [16] = '{20000, 50000, 70000, 100000, 15000, 23000, 31000, 40000,
                            93000, 105000, 118000, 131000, 10, 100, 1000, 11000};

  uodr_core #(.NUM_EP(NUM_EP)) dut_u (.*);
  uodr_host_model host (
    .clk_sys_i   (clk_sys_i),
    .session_o   (session_valid_cmp_i),
    .high_o      (high_power_valid_cmp_i),
    .id_o        (role_id_pin_i),
    .bus_reset_o (bus_reset_i),
    .hs_o        (host_hs_capable_i)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task tick(input integer n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task twrite(input u, input [1:0] p, input [1:0] v);
    begin
      timer_unlock_wr_i <= u;
      tick(1);
      timer_unlock_wr_i <= 1'b0;
      timer_wr_i <= 1'b1;
      timer_page_select_i <= p;
      timer_timeout_value_i <= v;
      tick(1);
      timer_wr_i <= 1'b0;
      tick(4);
    end
  endtask

  task results;
    begin
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  initial begin
    #100000;
    n_errors = n_errors + 1;
    results;
  end

  initial begin
    {rst_n_i, timer_unlock_wr_i, timer_wr_i, timer_page_select_i, timer_timeout_value_i,
     controller_enable_i, id_pin_enable_wr_i, software_role_select_i, clock_freeze_wr_i,
     detach_wr_i, high_speed_ok_i, bus_power_change_clr_i, role_change_clr_i} = 0;
    {end_of_bus_reset_clr_i, endpoint_enable_wr_i, endpoint_enable_i} = 0;
    {endpoint_reset_bit_i, toggle_reset_set_i, endpoint_event_i, toggle_reset_done_i} = 0;
    {id_pin_enable_i, clock_freeze_i, detach_i} = 3'h7;
    tick(4);
    rst_n_i <= 1'b1;
    tick(1);
    chk({id_pin_enable_o, role_status_o, clock_freeze_o, detach_o}, 4'hF);
    chk({device_state_o, memory_allocate_clr_o, pullup_dp_o}, 12'h3FE);
    // ----------------------------------------------------------------
    // Timer window
    // ----------------------------------------------------------------
    for (k = 0; k < 16; k = k + 1) begin
      twrite(1'b1, k[3:2], k[1:0]);
      chk({timer_page_select_o, timer_timeout_value_o}, k[3:0]);
      chk(timer_cycles_o, tus[k] * 200);
    end
    twrite(1'b0, 2'h0, 2'h1);
    chk({timer_page_select_o, timer_timeout_value_o}, 4'hF);
    {timer_unlock_wr_i, timer_wr_i} <= 2'h3;
    tick(1);
    {timer_unlock_wr_i, timer_wr_i} <= 2'h0;
    tick(3);
    chk({timer_page_select_o, timer_timeout_value_o}, 4'hF);
    twrite(1'b0, 2'h1, 2'h2);
    chk(timer_cycles_o, 32'd31000 * 200);
    // ----------------------------------------------------------------
    // Bus power and role
    // ----------------------------------------------------------------
    host.vbus(2'h1);
    tick(8);
    chk({bus_power_o, bus_power_change_flag_o}, 2'h3);
    bus_power_change_clr_i <= 1'b1;
    tick(1);
    bus_power_change_clr_i <= 1'b0;
    host.vbus(2'h0);
    tick(8);
    chk({bus_power_o, bus_power_change_flag_o}, 2'h1);
    host.plug(1'b1);
    tick(8);
    chk({role_status_o, role_change_flag_o}, 2'h1);
    role_change_clr_i <= 1'b1;
    tick(1);
    role_change_clr_i <= 1'b0;
    tick(1);
    chk(role_change_flag_o, 1'b0);
    host.vbus(2'h1);
    tick(8);
    chk(bus_power_o, 1'b0);
    host.vbus(2'h3);
    tick(8);
    chk(bus_power_o, 1'b1);
    host.vbus(2'h1);
    tick(8);
    chk(bus_power_o, 1'b1);
    host.vbus(2'h0);
    tick(8);
    chk(bus_power_o, 1'b0);
    id_pin_enable_wr_i <= 1'b1;
    id_pin_enable_i <= 1'b0;
    software_role_select_i <= 1'b1;
    tick(1);
    id_pin_enable_wr_i <= 1'b0;
    tick(8);
    chk({id_pin_enable_o, role_status_o}, 2'h1);
    {id_pin_enable_wr_i, id_pin_enable_i} <= 2'h3;
    tick(1);
    id_pin_enable_wr_i <= 1'b0;
    host.plug(1'b0);
    tick(8);
    chk({id_pin_enable_o, role_status_o}, 2'h3);
    // ----------------------------------------------------------------
    // Device states, bus reset, endpoint reset
    // ----------------------------------------------------------------
    controller_enable_i <= 1'b1;
    tick(2);
    chk(device_state_o, 3'h2);
    clock_freeze_wr_i <= 1'b1;
    clock_freeze_i <= 1'b0;
    high_speed_ok_i <= 1'b1;
    host.vbus(2'h1);
    tick(1);
    clock_freeze_wr_i <= 1'b0;
    tick(8);
    chk({device_state_o, pullup_dp_o}, 4'h8);
    detach_wr_i <= 1'b1;
    detach_i <= 1'b0;
    tick(1);
    detach_wr_i <= 1'b0;
    tick(3);
    chk(pullup_dp_o, 1'b1);
    for (k = 0; k < 2; k = k + 1) begin
      {endpoint_enable_wr_i, endpoint_enable_i, endpoint_event_i} <= 24'hFFFF08;
      tick(1);
      {endpoint_enable_wr_i, endpoint_event_i} <= 16'h0;
      host.reset_bus(8'd20, !k[0]);
      tick(3);
      chk({endpoint_enabled_o, toggle_reset_o[0], end_of_bus_reset_flag_o}, 10'h7);
      chk({speed_o, endpoint_irq_src_o[3]}, {1'b0, !k[0], 1'b1});
      end_of_bus_reset_clr_i <= 1'b1;
      toggle_reset_done_i <= 8'h01;
      tick(1);
      {end_of_bus_reset_clr_i, toggle_reset_done_i} <= 9'h0;
      tick(2);
      chk({end_of_bus_reset_flag_o, toggle_reset_o[0]}, 2'h0);
    end
    {endpoint_enable_wr_i, endpoint_enable_i, endpoint_event_i} <= 24'h040404;
    tick(1);
    {endpoint_enable_wr_i, endpoint_event_i, endpoint_reset_bit_i} <= 24'h000004;
    tick(2);
    chk({endpoint_in_reset_o[2], endpoint_enabled_o[2], endpoint_irq_src_o[2]}, 3'h6);
    {endpoint_reset_bit_i, toggle_reset_set_i} <= 16'h0020;
    tick(1);
    toggle_reset_set_i <= 8'h00;
    tick(2);
    chk({endpoint_in_reset_o[2], toggle_reset_o[5]}, 2'h1);
    controller_enable_i <= 1'b0;
    tick(3);
    chk({device_state_o, detach_o, pullup_dp_o}, 5'h6);
    controller_enable_i <= 1'b1;
    tick(2);
    host.plug(1'b1);
    tick(8);
    chk(device_state_o, 3'h1);
    results;
  end
endmodule

bind uodr_core uodr_core_props #(.NUM_EP(NUM_EP)) u_props (.*);
